// ---- verilog/dtc_pkg.sv ----
// dtc_pkg: shared constants and types for the dual timer/counter
package dtc_pkg;
    // register port addresses (8-bit sfr-style space)
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h01;
    localparam logic [7:0] ADDR_LOW0 = 8'h02;
    localparam logic [7:0] ADDR_HIGH0 = 8'h03;
    localparam logic [7:0] ADDR_LOW1 = 8'h04;
    localparam logic [7:0] ADDR_HIGH1 = 8'h05;
    localparam logic [7:0] ADDR_OPT = 8'h06;
    // mode register fields, nibble per timer: timer 1 upper, timer 0 lower
    localparam int MODE_T1_BASE = 4;
    localparam int MODE_T0_BASE = 0;
    localparam int MODE_LO_BIT = 0;
    localparam int MODE_HI_BIT = 1;
    localparam int MODE_CT_BIT = 2;
    localparam int MODE_GATE_BIT = 3;
    // control register fields
    localparam int CTRL_RUN0_BIT = 4;
    localparam int CTRL_OVF0_BIT = 5;
    localparam int CTRL_RUN1_BIT = 6;
    localparam int CTRL_OVF1_BIT = 7;
    // option register fields
    localparam int OPT_TOG0_BIT = 0;
    localparam int OPT_TOG1_BIT = 1;
    localparam int OPT_HALVE_BIT = 2;
    // reset values
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] OPT_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    // machine cycle length in cpu clocks
    localparam int MC_CLOCKS = 6;
    localparam int MC_CLOCKS_COMPAT = 12;
    localparam int MC_CNT_W = 4;
    localparam logic [MC_CNT_W-1:0] MC_LAST = 4'(MC_CLOCKS - 1);
    localparam logic [MC_CNT_W-1:0] MC_LAST_COMPAT = 4'(MC_CLOCKS_COMPAT - 1);
    localparam logic [4:0] MODE0_LOW_MAX = 5'h1f;

    typedef enum logic [1:0] {
        DTC_MODE_13 = 2'b00,
        DTC_MODE_16 = 2'b01,
        DTC_MODE_RELOAD = 2'b10,
        DTC_MODE_SPLIT = 2'b11
    } dtc_mode_t;

    // per-timer control as decoded from the mode nibble
    typedef struct packed {
        logic gate;
        logic counter;
        dtc_mode_t mode;
    } dtc_tcfg_t;

    // software write into a timer's count bytes
    typedef struct packed {
        logic low_we;
        logic high_we;
        logic [7:0] data;
    } dtc_wr_t;
endpackage

// ---- verilog/dtc_unit.sv ----
// dtc_unit: one timer/counter core with low and high count bytes
`timescale 1ns/1ns
module dtc_unit (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // configuration
    input wire dtc_pkg::dtc_tcfg_t cfg_i,
    input wire logic split_i,
    input wire logic low_en_i,
    input wire logic high_en_i,
    input wire dtc_pkg::dtc_wr_t wr_i,
    // state
    output logic [7:0] low_o,
    output logic [7:0] high_o,
    output logic low_ovf_o,
    output logic high_ovf_o
);
    logic [7:0] low_q;
    logic [7:0] low_d;
    logic [7:0] high_q;
    logic [7:0] high_d;
    wire logic [8:0] low_inc = {1'b0, low_q} + 9'h001;
    wire logic [8:0] high_inc = {1'b0, high_q} + 9'h001;
    wire logic low5_wrap = (low_q[4:0] == dtc_pkg::MODE0_LOW_MAX);
    wire logic is13 = (cfg_i.mode == dtc_pkg::DTC_MODE_13);
    wire logic is16 = (cfg_i.mode == dtc_pkg::DTC_MODE_16);
    wire logic isrl = (cfg_i.mode == dtc_pkg::DTC_MODE_RELOAD);
    // carry from low into high in the cascaded modes
    wire logic carry = low_en_i && ((is13 && low5_wrap) || (is16 && low_inc[8])); // R6 R11
    wire logic high_step = split_i ? high_en_i : carry;

    always_comb
    begin
        low_d = low_q;
        high_d = high_q;
        low_ovf_o = 1'b0;
        high_ovf_o = 1'b0;
        if (low_en_i)
        begin
            if (is13)
            begin
                // upper three low bits are left as they are
                low_d = {low_q[7:5], low_inc[4:0]}; // R6
            end
            else if (isrl && low_inc[8])
            begin
                low_d = high_q; // R12
            end
            else
            begin
                low_d = low_inc[7:0];
            end
        end
        if (high_step)
        begin
            high_d = high_inc[7:0];
        end
        if (split_i)
        begin
            low_ovf_o = low_en_i && low_inc[8]; // R14
            high_ovf_o = high_en_i && high_inc[8]; // R15
        end
        else if (isrl)
        begin
            low_ovf_o = low_en_i && low_inc[8]; // R12
        end
        else
        begin
            low_ovf_o = carry && high_inc[8]; // R7
        end
        // software write beats a same-cycle increment
        if (wr_i.low_we)
        begin
            low_d = wr_i.data; // R20
        end
        if (wr_i.high_we)
        begin
            high_d = wr_i.data; // R20
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            low_q <= dtc_pkg::COUNT_RST;
            high_q <= dtc_pkg::COUNT_RST;
        end
        else if (clk_en_i)
        begin
            low_q <= low_d;
            high_q <= high_d;
        end
    end

    assign low_o = low_q;
    assign high_o = high_q;
endmodule

// ---- verilog/dtc_top.sv ----
// dtc_top: two timer/counters with mode, control and option registers
// Functional notes
// R1: timer function counts once per machine cycle, one sixth of cpu clock
// R2: counter function samples pin each machine cycle, counts on high-then-low
// R3: counted edge shows in register the machine cycle after detection
// R4: pin source holds each level at least one machine cycle
// R5: per timer, counter-select bit and two-bit mode field
// R6: mode 0 is 13 bits: high byte plus low five bits of low byte
// R7: wrap from all ones to zero sets the timer overflow flag
// R8: count only when run bit set and gate clear or irq pin high
// R9: setting the run bit leaves count bytes unchanged
// R10: gate bits at mode register bit 7 for timer one, bit 3 timer zero
// R11: mode 1 uses all sixteen bits of both count bytes
// R12: mode 2 low byte counts, reloads from high byte on overflow
// R13: timer one in mode 3 stops as if its run bit were clear
// R14: timer zero mode 3 low byte uses timer zero controls and flag
// R15: timer zero mode 3 high byte counts cycles, uses timer one run and flag
// R16: with timer zero in mode 3, timer one runs without setting any flag
// R17: toggle enable makes each overflow invert the timer count pin; timer one and mode 3 high byte overflows in one cycle invert it once
// R18: toggle output drives high until the first overflow
// R19: machine cycle is six clocks, twelve with compatibility halving
// R20: software byte writes override a same-cycle increment
// R21: overflow flag stays set until software clear or interrupt acknowledge
// R22: in mode 3 timer zero high byte overflow toggles timer one pin
`timescale 1ns/1ns
module dtc_top (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    // interrupt controller
    input wire logic irq_ack_zero_i,
    input wire logic irq_ack_one_i,
    output logic overflow_flag_zero_o,
    output logic overflow_flag_one_o,
    // external pins
    input wire logic external_irq_pin_zero_i,
    input wire logic external_irq_pin_one_i,
    input wire logic count_pin_zero_i,
    input wire logic count_pin_one_i,
    output logic count_pin_zero_o,
    output logic count_pin_zero_oe_o,
    output logic count_pin_one_o,
    output logic count_pin_one_oe_o,
    // baud tick for a serial port
    output logic baud_tick_o
);
    logic [7:0] timer_mode_reg_q;
    logic [7:0] timer_control_reg_q;
    logic [7:0] timer_control_reg_d;
    logic [7:0] port_two_mode_reg_q;
    localparam int MC_W = dtc_pkg::MC_CNT_W;
    logic [MC_W-1:0] mc_cnt_q;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [1:0] samp_q;
    logic [1:0] edge_q;
    logic [1:0] tog_q;
    logic [7:0] rdata_q;
    logic [7:0] low0;
    logic [7:0] high0;
    logic [7:0] low1;
    logic [7:0] high1;
    logic ovf0_lo;
    logic ovf0_hi;
    logic ovf1_lo;

    // synchronised pins: 0 count0, 1 count1, 2 irq0, 3 irq1
    wire logic [3:0] pins_raw = {external_irq_pin_one_i, external_irq_pin_zero_i,
        count_pin_one_i, count_pin_zero_i};

    // machine cycle strobe
    wire logic halve = port_two_mode_reg_q[dtc_pkg::OPT_HALVE_BIT];
    wire logic [MC_W-1:0] mc_last = halve ? dtc_pkg::MC_LAST_COMPAT : dtc_pkg::MC_LAST; // R19
    // at or above: dropping the halve option mid-cycle must not run the counter to wrap
    wire logic mc_tick = (mc_cnt_q >= mc_last); // R1

    // per-timer configuration fields
    wire dtc_pkg::dtc_tcfg_t cfg0 = timer_mode_reg_q[dtc_pkg::MODE_T0_BASE +: 4]; // R5
    wire dtc_pkg::dtc_tcfg_t cfg1 = timer_mode_reg_q[dtc_pkg::MODE_T1_BASE +: 4]; // R5 R10
    wire logic run0 = timer_control_reg_q[dtc_pkg::CTRL_RUN0_BIT];
    wire logic run1 = timer_control_reg_q[dtc_pkg::CTRL_RUN1_BIT];
    wire logic split = (cfg0.mode == dtc_pkg::DTC_MODE_SPLIT);
    wire logic t1_m3 = (cfg1.mode == dtc_pkg::DTC_MODE_SPLIT);

    // count enables: gate qualifies the run bit
    wire logic qual0 = run0 && (!cfg0.gate || sync2_q[2]); // R8
    wire logic qual1 = run1 && (!cfg1.gate || sync2_q[3]); // R8
    wire logic step0 = cfg0.counter ? edge_q[0] : mc_tick; // R2
    wire logic step1 = cfg1.counter ? edge_q[1] : mc_tick; // R2
    wire logic en0_lo = qual0 && step0;
    // timer one ignores its run bit while timer zero borrows it
    wire logic en1_lo = !t1_m3 && (split || qual1) && step1; // R13 R16
    wire logic en0_hi = split && run1 && mc_tick; // R15

    // overflow events per timer
    wire logic ev0 = ovf0_lo;
    wire logic ev1_flag = split ? ovf0_hi : ovf1_lo; // R15 R16
    wire logic ev1_tog = ovf1_lo || (split && ovf0_hi); // R22
    wire logic [1:0] tog_en = {port_two_mode_reg_q[dtc_pkg::OPT_TOG1_BIT],
        port_two_mode_reg_q[dtc_pkg::OPT_TOG0_BIT]};
    wire logic [1:0] tog_ev = {ev1_tog, ev0};

    // register decode
    wire logic wr_mode = reg_we_i && (reg_addr_i == dtc_pkg::ADDR_MODE);
    wire logic wr_ctrl = reg_we_i && (reg_addr_i == dtc_pkg::ADDR_CTRL);
    wire logic wr_opt = reg_we_i && (reg_addr_i == dtc_pkg::ADDR_OPT);
    wire dtc_pkg::dtc_wr_t wr0 = '{low_we: reg_we_i && (reg_addr_i == dtc_pkg::ADDR_LOW0),
        high_we: reg_we_i && (reg_addr_i == dtc_pkg::ADDR_HIGH0), data: reg_wdata_i};
    wire dtc_pkg::dtc_wr_t wr1 = '{low_we: reg_we_i && (reg_addr_i == dtc_pkg::ADDR_LOW1),
        high_we: reg_we_i && (reg_addr_i == dtc_pkg::ADDR_HIGH1), data: reg_wdata_i};
    wire logic [7:0] rmux =
        (reg_addr_i == dtc_pkg::ADDR_MODE) ? timer_mode_reg_q :
        (reg_addr_i == dtc_pkg::ADDR_CTRL) ? timer_control_reg_q :
        (reg_addr_i == dtc_pkg::ADDR_LOW0) ? low0 :
        (reg_addr_i == dtc_pkg::ADDR_HIGH0) ? high0 :
        (reg_addr_i == dtc_pkg::ADDR_LOW1) ? low1 :
        (reg_addr_i == dtc_pkg::ADDR_HIGH1) ? high1 :
        (reg_addr_i == dtc_pkg::ADDR_OPT) ? port_two_mode_reg_q : 8'h00;

    // flags: hardware set wins over software clear or acknowledge
    always_comb
    begin
        timer_control_reg_d = timer_control_reg_q;
        if (wr_ctrl)
        begin
            // writing the run bit touches no count byte
            timer_control_reg_d = reg_wdata_i; // R9
        end
        if (irq_ack_zero_i)
        begin
            timer_control_reg_d[dtc_pkg::CTRL_OVF0_BIT] = 1'b0; // R21
        end
        if (irq_ack_one_i)
        begin
            timer_control_reg_d[dtc_pkg::CTRL_OVF1_BIT] = 1'b0; // R21
        end
        if (ev0)
        begin
            timer_control_reg_d[dtc_pkg::CTRL_OVF0_BIT] = 1'b1; // R7 R14
        end
        if (ev1_flag)
        begin
            timer_control_reg_d[dtc_pkg::CTRL_OVF1_BIT] = 1'b1; // R7 R15
        end
    end

    dtc_unit u_timer0 (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .clk_en_i(clk_en_i),
        .cfg_i(cfg0),
        .split_i(split),
        .low_en_i(en0_lo),
        .high_en_i(en0_hi),
        .wr_i(wr0),
        .low_o(low0),
        .high_o(high0),
        .low_ovf_o(ovf0_lo),
        .high_ovf_o(ovf0_hi)
    );

    // timer one never splits; its mode 3 is simply stopped
    dtc_unit u_timer1 (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .clk_en_i(clk_en_i),
        .cfg_i(cfg1),
        .split_i(1'b0),
        .low_en_i(en1_lo),
        .high_en_i(1'b0),
        .wr_i(wr1),
        .low_o(low1),
        .high_o(high1),
        .low_ovf_o(ovf1_lo),
        .high_ovf_o()
    );

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            timer_mode_reg_q <= dtc_pkg::MODE_RST;
            timer_control_reg_q <= dtc_pkg::CTRL_RST;
            port_two_mode_reg_q <= dtc_pkg::OPT_RST;
            mc_cnt_q <= '0;
            rdata_q <= 8'h00;
        end
        else if (clk_en_i)
        begin
            if (wr_mode)
            begin
                timer_mode_reg_q <= reg_wdata_i;
            end
            if (wr_opt)
            begin
                port_two_mode_reg_q <= reg_wdata_i;
            end
            timer_control_reg_q <= timer_control_reg_d;
            mc_cnt_q <= mc_tick ? '0 : mc_cnt_q + 1'b1; // R1 R19
            if (reg_re_i)
            begin
                rdata_q <= rmux;
            end
        end
    end

    // two-flop synchronisers; only the second stage feeds logic
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end
        else if (clk_en_i)
        begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    // per-timer pin sampling and toggle output
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_pin
            always_ff @(posedge core_clk_i)
            begin
                if (!resetn_i)
                begin
                    samp_q[g] <= 1'b0;
                    edge_q[g] <= 1'b0;
                    tog_q[g] <= 1'b1;
                end
                else if (clk_en_i)
                begin
                    // edge found at a tick, counted on the clock right after that tick
                    if (mc_tick)
                    begin
                        samp_q[g] <= sync2_q[g]; // R2
                        edge_q[g] <= samp_q[g] && !sync2_q[g]; // R3
                    end
                    else
                    begin
                        edge_q[g] <= 1'b0;
                    end
                    if (!tog_en[g])
                    begin
                        tog_q[g] <= 1'b1; // R18
                    end
                    else if (tog_ev[g])
                    begin
                        tog_q[g] <= !tog_q[g]; // R17 R22
                    end
                end
            end
        end
    endgenerate

    assign reg_rdata_o = rdata_q;
    assign overflow_flag_zero_o = timer_control_reg_q[dtc_pkg::CTRL_OVF0_BIT];
    assign overflow_flag_one_o = timer_control_reg_q[dtc_pkg::CTRL_OVF1_BIT];
    assign count_pin_zero_o = tog_q[0];
    assign count_pin_one_o = tog_q[1];
    assign count_pin_zero_oe_o = tog_en[0]; // R17
    assign count_pin_one_oe_o = tog_en[1]; // R17
    // timer one overflow still serves baud generation when it sets no flag
    assign baud_tick_o = ovf1_lo; // R16
endmodule

// ---- dv/dtc_pin_model.sv ----
// dtc_pin_model: external source for the count and interrupt pins
`timescale 1ns/1ns
module dtc_pin_model (
    // clock
    input wire logic core_clk_i,
    // requests from the bench
    input wire logic [1:0] fall_req_i,
    input wire logic [1:0] gate_lvl_i,
    // pins
    output logic [1:0] count_pin_o,
    output logic [1:0] irq_pin_o
);
    logic [5:0] hold_q [2] = '{6'h00, 6'h00};
    // 16 clocks low then 16 high, longer than even a 12-clock machine cycle
    always @(posedge core_clk_i)
        for (int k = 0; k < 2; k++)
            if (hold_q[k] != 6'h00)
                hold_q[k] <= hold_q[k] - 6'h01;
            else if (fall_req_i[k])
                hold_q[k] <= 6'h20;
    // pins idle high, as with a pull-up
    always_comb
        for (int k = 0; k < 2; k++)
            count_pin_o[k] = !(hold_q[k] > 6'h10);
    assign irq_pin_o = gate_lvl_i;
endmodule

// ---- dv/dtc_top_properties.sv ----
// dtc_top_properties: port-level checks for the dual timer/counter
`timescale 1ns/1ns
module dtc_top_properties (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    input wire logic [7:0] reg_rdata_o,
    // flags and pins
    input wire logic irq_ack_zero_i,
    input wire logic irq_ack_one_i,
    input wire logic overflow_flag_zero_o,
    input wire logic overflow_flag_one_o,
    input wire logic count_pin_zero_o,
    input wire logic count_pin_zero_oe_o,
    input wire logic count_pin_one_o,
    input wire logic count_pin_one_oe_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    wire wr_ctrl = reg_we_i && clk_en_i && reg_addr_i == dtc_pkg::ADDR_CTRL;
    wire wr_opt = reg_we_i && clk_en_i && reg_addr_i == dtc_pkg::ADDR_OPT;

    reset_outputs_a: assert property ($rose(resetn_i) |-> count_pin_zero_o && count_pin_one_o
        && !overflow_flag_zero_o && !overflow_flag_one_o && reg_rdata_o == 8'h00)
        else $error("outputs not at reset level");
    ovf0_clear_a: assert property ($fell(overflow_flag_zero_o)
        |-> $past(irq_ack_zero_i || wr_ctrl || !resetn_i)) else $error("flag 0 dropped alone");
    ovf1_clear_a: assert property ($fell(overflow_flag_one_o)
        |-> $past(irq_ack_one_i || wr_ctrl || !resetn_i)) else $error("flag 1 dropped alone");
    tog0_start_a: assert property ($rose(count_pin_zero_oe_o) |-> count_pin_zero_o)
        else $error("pin 0 not high at enable");
    tog1_start_a: assert property ($rose(count_pin_one_oe_o) |-> count_pin_one_o)
        else $error("pin 1 not high at enable");
    opt_enable_a: assert property (wr_opt |=> count_pin_zero_oe_o == $past(reg_wdata_i[0])
        && count_pin_one_oe_o == $past(reg_wdata_i[1])) else $error("enable not from write");
    rdata_hold_a: assert property (!(reg_re_i && clk_en_i) |=> $stable(reg_rdata_o))
        else $error("read data moved without read");
    unmapped_read_a: assert property (reg_re_i && clk_en_i && reg_addr_i > dtc_pkg::ADDR_OPT
        |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    freeze_hold_a: assert property (!clk_en_i |=> $stable(overflow_flag_zero_o)
        && $stable(count_pin_zero_o) && $stable(reg_rdata_o)) else $error("state moved frozen");
endmodule

bind dtc_top dtc_top_properties i_props (
    .core_clk_i,
    .resetn_i,
    .clk_en_i,
    .reg_addr_i,
    .reg_wdata_i,
    .reg_we_i,
    .reg_re_i,
    .reg_rdata_o,
    .irq_ack_zero_i,
    .irq_ack_one_i,
    .overflow_flag_zero_o,
    .overflow_flag_one_o,
    .count_pin_zero_o,
    .count_pin_zero_oe_o,
    .count_pin_one_o,
    .count_pin_one_oe_o
);

// ---- dv/dtc_top_tb.sv ----
// dtc_top_tb: directed bench for the dual timer/counter
`timescale 1ns/1ns
module dtc_top_tb;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_we_i = 1'b0;
    logic reg_re_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic [1:0] ack = 2'b00;
    logic [1:0] fall_req = 2'b00;
    logic [1:0] gate_lvl = 2'b11;
    logic [1:0] mdl_pin;
    logic [1:0] irq_pin;
    logic [1:0] flag;
    logic [1:0] tog;
    logic [1:0] tog_oe;
    logic baud_tick;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    int baud_cnt = 0;
    // mode, ctrl, option, low, high, low mask, low, high, low one, flags after 3 ticks
    logic [7:0] tbl [7][10] = '{
        '{8'h00, 8'h10, 8'h03, 8'h1f, 8'hff, 8'h1f, 8'h02, 8'h00, 8'h00, 8'h01},
        '{8'h01, 8'h10, 8'h03, 8'hff, 8'hff, 8'hff, 8'h02, 8'h00, 8'h00, 8'h01},
        '{8'h02, 8'h10, 8'h03, 8'hff, 8'hf0, 8'hff, 8'hf2, 8'hf0, 8'h00, 8'h01},
        '{8'h09, 8'h10, 8'h03, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00},
        '{8'h33, 8'h50, 8'h03, 8'hff, 8'hff, 8'hff, 8'h02, 8'h02, 8'h00, 8'h03},
        '{8'h13, 8'h50, 8'h03, 8'hff, 8'hff, 8'hff, 8'h02, 8'h02, 8'h04, 8'h03},
        '{8'h01, 8'h10, 8'h07, 8'hff, 8'hff, 8'hff, 8'h02, 8'h00, 8'h00, 8'h01}
    };
    // the device drives the shared pin only while its toggle output is enabled
    wire pin0 = tog_oe[0] ? tog[0] : mdl_pin[0];
    wire pin1 = tog_oe[1] ? tog[1] : mdl_pin[1];

    dtc_top i_dut (
        .core_clk_i,
        .resetn_i,
        .clk_en_i,
        .reg_addr_i,
        .reg_wdata_i,
        .reg_we_i,
        .reg_re_i,
        .reg_rdata_o,
        .irq_ack_zero_i(ack[0]),
        .irq_ack_one_i(ack[1]),
        .overflow_flag_zero_o(flag[0]),
        .overflow_flag_one_o(flag[1]),
        .external_irq_pin_zero_i(irq_pin[0]),
        .external_irq_pin_one_i(irq_pin[1]),
        .count_pin_zero_i(pin0),
        .count_pin_one_i(pin1),
        .count_pin_zero_o(tog[0]),
        .count_pin_zero_oe_o(tog_oe[0]),
        .count_pin_one_o(tog[1]),
        .count_pin_one_oe_o(tog_oe[1]),
        .baud_tick_o(baud_tick)
    );
    dtc_pin_model i_pins (
        .core_clk_i,
        .fall_req_i(fall_req),
        .gate_lvl_i(gate_lvl),
        .count_pin_o(mdl_pin),
        .irq_pin_o(irq_pin)
    );

    always #4 core_clk_i = ~core_clk_i;

    // timer one overflow pulses, counted at the edges where the design takes them
    always @(posedge core_clk_i)
        if (baud_tick && clk_en_i && resetn_i)
            baud_cnt <= baud_cnt + 1;

    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge core_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            results();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_we_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge core_clk_i);
        reg_re_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_re_i <= 1'b0;
        #1;
        check(reg_rdata_o & m, exp);
    endtask

    // run window of 3 machine cycles between the run and stop writes
    task automatic run_case(input int i);
        logic [7:0] t [10];
        t = tbl[i];
        wr(dtc_pkg::ADDR_CTRL, 8'h00);
        wr(dtc_pkg::ADDR_OPT, 8'h00);
        wr(dtc_pkg::ADDR_OPT, t[2]);
        gate_lvl <= {1'b1, !t[0][3]};
        wr(dtc_pkg::ADDR_LOW0, t[3]);
        wr(dtc_pkg::ADDR_HIGH0, t[4]);
        wr(dtc_pkg::ADDR_LOW1, 8'h00);
        wr(dtc_pkg::ADDR_HIGH1, 8'h00);
        wr(dtc_pkg::ADDR_MODE, t[0]);
        wr(dtc_pkg::ADDR_CTRL, t[1]);
        repeat (t[2][2] ? 32 : 14) @(posedge core_clk_i);
        #1;
        check(8'(flag), t[9]);
        check(8'(tog), ~t[9] & 8'h03);
        @(posedge core_clk_i);
        ack <= 2'b11;
        @(posedge core_clk_i);
        ack <= 2'b00;
        #1;
        check(8'(flag), 8'h00);
        wr(dtc_pkg::ADDR_CTRL, 8'h00);
        repeat (2) @(posedge core_clk_i);
        wr(dtc_pkg::ADDR_MODE, t[0] | 8'h30);
        rd_chk(dtc_pkg::ADDR_LOW0, t[5], t[6]);
        rd_chk(dtc_pkg::ADDR_HIGH0, 8'hff, t[7]);
        rd_chk(dtc_pkg::ADDR_LOW1, 8'hff, t[8]);
    endtask

    initial
    begin
        repeat (10) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        for (int a = 0; a < 8; a++)
            rd_chk(8'(a), 8'hff, 8'h00);
        @(posedge core_clk_i);
        clk_en_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        clk_en_i <= 1'b1;
        wr(dtc_pkg::ADDR_MODE, 8'h05);
        wr(dtc_pkg::ADDR_CTRL, 8'h10);
        repeat (3)
        begin
            @(posedge core_clk_i);
            fall_req <= 2'b01;
            @(posedge core_clk_i);
            fall_req <= 2'b00;
            repeat (40) @(posedge core_clk_i);
        end
        rd_chk(dtc_pkg::ADDR_LOW0, 8'hff, 8'h03);
        // timer one reloads from fe: four ticks, overflows at the first and third
        wr(dtc_pkg::ADDR_MODE, 8'h20);
        wr(dtc_pkg::ADDR_LOW1, 8'hff);
        wr(dtc_pkg::ADDR_HIGH1, 8'hfe);
        wr(dtc_pkg::ADDR_CTRL, 8'h40);
        repeat (22) @(posedge core_clk_i);
        #1;
        check(8'(flag), 8'h02);
        wr(dtc_pkg::ADDR_CTRL, 8'h00);
        rd_chk(dtc_pkg::ADDR_LOW1, 8'hff, 8'hff);
        check(8'(baud_cnt), 8'h02);
        foreach (tbl[i])
            run_case(i);
        results();
    end
endmodule
